// ===== hdl/pec_pkg.sv
// Purpose: shared constants for the paired event counter block
// Assumes: one 20 MHz processor clock, register access by index
// Notes: setup field positions and count register geometry

package pec_pkg;

    // processor clock period
    localparam int CLK_PERIOD_NS = 50;

    // counter geometry
    localparam int NUM_CTR = 2;
    localparam int CNT_W = 40;
    localparam int WR_W = 32;
    localparam int TOT_W = 4;

    // register indices on the model register port
    localparam logic [1:0] IDX_SETUP_FIRST = 2'h0;
    localparam logic [1:0] IDX_SETUP_SECOND = 2'h1;
    localparam logic [1:0] IDX_COUNT_FIRST = 2'h2;
    localparam logic [1:0] IDX_COUNT_SECOND = 2'h3;

    // setup register fields
    localparam int EVT_CODE_LSB = 0;
    localparam int EVT_CODE_MSB = 7;
    localparam int QUAL_LSB = 8;
    localparam int QUAL_MSB = 15;
    localparam int USR_BIT = 16;
    localparam int KRN_BIT = 17;
    localparam int EDGE_BIT = 18;
    localparam int PIN_SEL_BIT = 19;
    localparam int INT_BIT = 20;
    localparam int EN_BIT = 22;
    localparam int FLIP_BIT = 23;
    localparam int THR_LSB = 24;
    localparam int THR_MSB = 31;

    // writable bits; bit 21 reserved, enable only in the first register
    localparam logic [31:0] SETUP_MASK_FIRST = 32'hffdf_ffff;
    localparam logic [31:0] SETUP_MASK_SECOND = 32'hff9f_ffff;

    // reset values
    localparam logic [31:0] SETUP_RESET = 32'h0000_0000;
    localparam logic [39:0] COUNT_RESET = 40'h00_0000_0000;

    // privilege level that may use the model register instructions
    localparam logic [1:0] CPL_KERNEL = 2'h0;

    // bus clock is the processor clock divided by four
    localparam int BUS_DIV = 4;
    localparam logic [1:0] BUS_DIV_LAST = 2'(BUS_DIV - 1);

endpackage

// ===== hdl/pec_top.sv
// Purpose: two 40-bit event or duration counters with setup registers
// Assumes: event logic reports the per-cycle qualified total per counter
// Notes: model register port needs privilege 0, counter read port does not
//
// Functional notes
// [R1] two independent 40-bit counters, each with its own setup
// [R2] duration counts clocks while condition holds; event mode counts occurrences
// [R3] setup and count registers reach model register port only at privilege 0
// [R4] counter read port returns counts at any privilege level
// [R5] setup bits 0-7 hold event code steering the event unit
// [R6] setup bits 8-15 hold qualifier narrowing the chosen event
// [R7] bit 16 set: count while privilege is 1, 2 or 3
// [R8] bit 17 set: count at privilege 0; both bits: all levels
// [R9] bit 18 set: count rising transitions only; back-to-back merges
// [R10] bit 19 set: pin toggles per counted event; clear: on overflow
// [R11] each pin toggle is high for exactly one bus clock
// [R12] bit 20 set: overflow raises interrupt request to controller
// [R13] bit 22 of first setup only: enables or stops both counters
// [R14] bit 23 picks greater-or-equal or less-than; ignored at zero threshold
// [R15] nonzero threshold in bits 24-31: add one when comparison passes
// [R16] zero threshold without bit 18: add the full qualified total each cycle
// [R17] count write keeps low 32 bits, upper 8 copy bit 31
// [R18] counting starts after enabling write; clearing second setup stops second
// [R19] overflow is a carry past the all-ones 40-bit value
// [R20] both privilege bits clear: counter holds

`timescale 1ns/1ns

module pec_top
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,

    // processor privilege state
    input wire logic [1:0] cpl,

    // model register read and write instructions
    input wire logic msr_req,
    input wire logic msr_wr,
    input wire logic [1:0] msr_idx,
    input wire logic [31:0] msr_wdata,
    output logic msr_ack,
    output logic msr_fault,
    output logic [39:0] msr_rdata,

    // counter read instruction
    input wire logic pmc_req,
    input wire logic pmc_sel,
    output logic pmc_ack,
    output logic [39:0] pmc_rdata,

    // event detection units
    output logic [7:0] event_code_first,
    output logic [7:0] event_code_second,
    output logic [7:0] event_qualifier_field_first,
    output logic [7:0] event_qualifier_field_second,
    input wire logic [3:0] event_total_first,
    input wire logic [3:0] event_total_second,

    // monitor pins and interrupt requests
    output logic [1:0] monitor_pin,
    output logic [1:0] perf_irq
);

    // shared decode
    wire kernel_mode;
    wire access_ok;
    wire wr_ok;
    wire rd_ok;
    wire global_en;
    wire bus_tick;
    logic [1:0] bus_div_reg;
    logic [1:0] bus_div_next;

    logic [31:0] setup_w [pec_pkg::NUM_CTR];
    logic [39:0] count_w [pec_pkg::NUM_CTR];
    logic [3:0] total_w [pec_pkg::NUM_CTR];
    logic [pec_pkg::NUM_CTR-1:0] setup_wr_w;
    logic [pec_pkg::NUM_CTR-1:0] count_wr_w;
    logic [pec_pkg::NUM_CTR-1:0] pin_w;
    logic [pec_pkg::NUM_CTR-1:0] irq_w;

    wire [39:0] msr_rd_mux;
    wire [39:0] pmc_rd_mux;
    wire [39:0] wr_sext;

    assign kernel_mode = (cpl == pec_pkg::CPL_KERNEL);
    assign access_ok = msr_req & kernel_mode; // [R3]
    assign wr_ok = access_ok & msr_wr;
    assign rd_ok = access_ok & ~msr_wr;
    assign global_en = setup_w[0][pec_pkg::EN_BIT]; // [R13]
    assign wr_sext = {{8{msr_wdata[31]}}, msr_wdata}; // [R17]

    assign setup_wr_w[0] = wr_ok & (msr_idx == pec_pkg::IDX_SETUP_FIRST);
    assign setup_wr_w[1] = wr_ok & (msr_idx == pec_pkg::IDX_SETUP_SECOND);
    assign count_wr_w[0] = wr_ok & (msr_idx == pec_pkg::IDX_COUNT_FIRST);
    assign count_wr_w[1] = wr_ok & (msr_idx == pec_pkg::IDX_COUNT_SECOND);

    assign total_w[0] = event_total_first;
    assign total_w[1] = event_total_second;

    // register read selection
    assign msr_rd_mux = (msr_idx == pec_pkg::IDX_SETUP_FIRST) ? {8'h00, setup_w[0]} :
                        (msr_idx == pec_pkg::IDX_SETUP_SECOND) ? {8'h00, setup_w[1]} :
                        (msr_idx == pec_pkg::IDX_COUNT_FIRST) ? count_w[0] :
                        count_w[1];
    assign pmc_rd_mux = pmc_sel ? count_w[1] : count_w[0]; // [R4]

    // bus clock enable from the processor clock
    assign bus_tick = (bus_div_reg == pec_pkg::BUS_DIV_LAST);
    assign bus_div_next = bus_tick ? 2'h0 : bus_div_reg + 2'h1;

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            bus_div_reg <= 2'h0;
        end
        else
        begin
            bus_div_reg <= bus_div_next;
        end
    end

    // per-counter datapath
    genvar gi;
    generate
        for (gi = 0; gi < pec_pkg::NUM_CTR; gi++)
        begin : g_ctr
            logic [31:0] setup_reg;
            logic [31:0] setup_next;
            logic [39:0] count_reg;
            logic [39:0] count_next;
            logic cond_prev_reg;
            logic pend_reg;
            logic pend_next;
            logic pin_reg;
            logic pin_next;
            logic irq_reg;

            wire [7:0] thr;
            wire thr_nz;
            wire flip;
            wire cmp_pass;
            wire cond;
            wire priv_ok;
            wire active;
            wire qual;
            wire hit;
            wire [39:0] inc;
            wire [40:0] sum;
            wire ovf;
            wire pin_evt;
            wire [31:0] setup_mask;

            assign setup_mask = (gi == 0) ? pec_pkg::SETUP_MASK_FIRST : pec_pkg::SETUP_MASK_SECOND;
            assign thr = setup_reg[pec_pkg::THR_MSB:pec_pkg::THR_LSB];
            assign thr_nz = (thr != 8'h00);
            assign flip = setup_reg[pec_pkg::FLIP_BIT] & thr_nz; // [R14]
            assign cmp_pass = flip ? ({4'h0, total_w[gi]} < thr) : ({4'h0, total_w[gi]} >= thr); // [R14]
            assign cond = thr_nz ? cmp_pass : (total_w[gi] != 4'h0); // [R2]

            // privilege filter; both flags clear leaves nothing to count
            assign priv_ok = (setup_reg[pec_pkg::USR_BIT] & ~kernel_mode) // [R7] [R20]
                           | (setup_reg[pec_pkg::KRN_BIT] & kernel_mode); // [R8] [R20]
            assign active = global_en & priv_ok; // [R13] [R18]
            assign qual = active & cond;
            assign hit = setup_reg[pec_pkg::EDGE_BIT] ? (qual & ~cond_prev_reg) : qual; // [R9]

            // one per pass under threshold or edge, else full total
            assign inc = (setup_reg[pec_pkg::EDGE_BIT] | thr_nz) ? 40'h00_0000_0001 // [R15]
                       : {36'h0_0000_0000, total_w[gi]}; // [R16]
            assign sum = {1'b0, count_reg} + {1'b0, inc};
            assign ovf = hit & sum[40]; // [R19]

            assign setup_next = setup_wr_w[gi] ? (msr_wdata & setup_mask) : setup_reg;
            assign count_next = count_wr_w[gi] ? wr_sext : // [R17]
                                hit ? sum[39:0] : count_reg; // [R1]

            // pin request held until a bus clock edge finds the pin low
            assign pin_evt = setup_reg[pec_pkg::PIN_SEL_BIT] ? hit : ovf; // [R10]
            assign pend_next = pin_evt | (pend_reg & ~(bus_tick & ~pin_reg));
            assign pin_next = bus_tick ? (pend_reg & ~pin_reg) : pin_reg; // [R11]

            always_ff @(posedge ref_clk or negedge rst_n)
            begin
                if (!rst_n)
                begin
                    setup_reg <= pec_pkg::SETUP_RESET;
                    count_reg <= pec_pkg::COUNT_RESET;
                end
                else
                begin
                    setup_reg <= setup_next; // [R3]
                    count_reg <= count_next; // [R3]
                end
            end

            always_ff @(posedge ref_clk or negedge rst_n)
            begin
                if (!rst_n)
                begin
                    cond_prev_reg <= 1'b0;
                    pend_reg <= 1'b0;
                    pin_reg <= 1'b0;
                    irq_reg <= 1'b0;
                end
                else
                begin
                    cond_prev_reg <= qual; // [R9]
                    pend_reg <= pend_next;
                    pin_reg <= pin_next; // [R11]
                    irq_reg <= ovf & setup_reg[pec_pkg::INT_BIT]; // [R12]
                end
            end

            assign setup_w[gi] = setup_reg;
            assign count_w[gi] = count_reg;
            assign pin_w[gi] = pin_reg;
            assign irq_w[gi] = irq_reg;
        end
    endgenerate

    // event unit steering straight from the setup registers
    assign event_code_first = setup_w[0][pec_pkg::EVT_CODE_MSB:pec_pkg::EVT_CODE_LSB]; // [R5]
    assign event_code_second = setup_w[1][pec_pkg::EVT_CODE_MSB:pec_pkg::EVT_CODE_LSB]; // [R5]
    assign event_qualifier_field_first = setup_w[0][pec_pkg::QUAL_MSB:pec_pkg::QUAL_LSB]; // [R6]
    assign event_qualifier_field_second = setup_w[1][pec_pkg::QUAL_MSB:pec_pkg::QUAL_LSB]; // [R6]
    assign monitor_pin = pin_w;
    assign perf_irq = irq_w;

    // answers, one cycle after the request
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            msr_ack <= 1'b0;
            msr_fault <= 1'b0;
            msr_rdata <= 40'h00_0000_0000;
            pmc_ack <= 1'b0;
            pmc_rdata <= 40'h00_0000_0000;
        end
        else
        begin
            msr_ack <= msr_req;
            msr_fault <= msr_req & ~kernel_mode; // [R3]
            msr_rdata <= rd_ok ? msr_rd_mux : 40'h00_0000_0000;
            pmc_ack <= pmc_req;
            pmc_rdata <= pmc_req ? pmc_rd_mux : 40'h00_0000_0000; // [R4]
        end
    end

endmodule

// ===== tb/pec_event_src.sv
// Purpose: event source model for one counter
// Assumes: a zero event code selects no detection unit
// Notes: bench commands the per-cycle activity
`timescale 1ns/1ns
module pec_event_src
(
    // selection from the block
    input wire logic [7:0] code,
    // commanded activity and reported total
    input wire logic [3:0] act,
    output logic [3:0] total
);
    assign total = (code == 8'h00) ? 4'h0 : act;
endmodule

// ===== tb/pec_top_assertions.sv
// Purpose: port checks for the paired event counters
// Assumes: bound to every block instance
// Notes: answers come one cycle after a request
`timescale 1ns/1ns
module pec_top_checker
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // watched ports
    input wire logic [1:0] cpl,
    input wire logic msr_req,
    input wire logic msr_wr,
    input wire logic [1:0] msr_idx,
    input wire logic [31:0] msr_wdata,
    input wire logic msr_ack,
    input wire logic msr_fault,
    input wire logic [39:0] msr_rdata,
    input wire logic pmc_req,
    input wire logic pmc_ack,
    input wire logic [39:0] pmc_rdata,
    input wire logic [7:0] event_code_first,
    input wire logic [1:0] monitor_pin,
    input wire logic [1:0] perf_irq
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    wire kwr = msr_req && msr_wr && cpl == pec_pkg::CPL_KERNEL;
    AST_MSR_ANSWER: assert property (msr_req |=> msr_ack && msr_fault == ($past(cpl) != 2'h0))
        else $error("model register answer wrong");
    AST_ACK_QUIET: assert property (!msr_req |=> !msr_ack && !msr_fault)
        else $error("model register answer without request");
    AST_FAULT_DATA: assert property (msr_req && cpl != 2'h0 |=> msr_rdata == 40'h0)
        else $error("refused access returned data");
    AST_PMC_ANSWER: assert property (pmc_req |=> pmc_ack)
        else $error("counter read not answered");
    AST_PMC_IDLE: assert property (!pmc_req |=> !pmc_ack && pmc_rdata == 40'h0)
        else $error("counter read data without request");
    AST_CODE: assert property (kwr && msr_idx == 2'h0 |=> event_code_first == $past(msr_wdata[7:0]))
        else $error("event code not taken from setup");
    AST_PIN_PULSE: assert property ($rose(monitor_pin[0]) |-> monitor_pin[0] [*4] ##1 !monitor_pin[0])
        else $error("monitor pin pulse not one bus clock");
    AST_IRQ_PULSE: assert property (perf_irq[0] |=> !perf_irq[0])
        else $error("interrupt request longer than one cycle");
    COV_FAULT: cover property (msr_ack && msr_fault);
    COV_PIN: cover property ($rose(monitor_pin[0]));
    COV_IRQ: cover property (perf_irq[0]);
endmodule
bind pec_top pec_top_checker i_chk (.ref_clk, .rst_n, .cpl, .msr_req, .msr_wr, .msr_idx, .msr_wdata, .msr_ack,
    .msr_fault, .msr_rdata, .pmc_req, .pmc_ack, .pmc_rdata, .event_code_first, .monitor_pin, .perf_irq);

// ===== tb/tb_perf_event_counter_pair.sv
// Purpose: self-checking bench for the paired event counters
// Assumes: inputs change 5 ns after the rising edge
// Notes: each run clears counts, loads setups, then drives activity
`timescale 1ns/1ns
module tb_perf_event_counter_pair;
    logic ref_clk = 1'h0, rst_n = 1'h0, msr_req = 1'h0, msr_wr = 1'h0, pmc_req = 1'h0, pmc_sel = 1'h0;
    logic [1:0] cpl = 2'h0, msr_idx = 2'h0, monitor_pin, perf_irq;
    logic [31:0] msr_wdata = 32'h0;
    logic [3:0] act0 = 4'h0, act1 = 4'h0, tot0, tot1;
    logic msr_ack, msr_fault, pmc_ack;
    logic [39:0] msr_rdata, pmc_rdata, rd;
    logic [7:0] ec0, ec1, eq0, eq1;
    int error_cnt = 0, total_checks = 0;
    pec_top i_dut (.ref_clk, .rst_n, .cpl, .msr_req, .msr_wr, .msr_idx, .msr_wdata, .msr_ack, .msr_fault,
        .msr_rdata, .pmc_req, .pmc_sel, .pmc_ack, .pmc_rdata, .event_code_first(ec0), .event_code_second(ec1),
        .event_qualifier_field_first(eq0), .event_qualifier_field_second(eq1), .event_total_first(tot0),
        .event_total_second(tot1), .monitor_pin, .perf_irq);
    pec_event_src i_src0 (.code(ec0), .act(act0), .total(tot0));
    pec_event_src i_src1 (.code(ec1), .act(act1), .total(tot1));
    initial
    begin
        forever #25 ref_clk = ~ref_clk;
    end
    task automatic chk(input string n, input logic [39:0] s, input logic [39:0] e);
        total_checks++;
        if (s !== e)
        begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk) #5;
    endtask
    task automatic msr(input logic w, input logic [1:0] i, input logic [31:0] d);
        tick(1);
        {msr_req, msr_wr, msr_idx, msr_wdata} = {1'h1, w, i, d};
        tick(1);
        msr_req = 1'h0;
        chk("msr_ack", msr_ack, 1'h1);
        chk("msr_fault", msr_fault, cpl != 2'h0);
        rd = msr_rdata;
    endtask
    task automatic pmc(input logic s, input logic [39:0] e);
        tick(1);
        {pmc_req, pmc_sel} = {1'h1, s};
        tick(1);
        pmc_req = 1'h0;
        chk("pmc_rdata", pmc_ack ? pmc_rdata : 40'hx, e);
    endtask
    task automatic t_regs();
        msr(1'h0, pec_pkg::IDX_SETUP_FIRST, 32'h0);
        chk("setup reset", rd, 40'h0);
        msr(1'h1, pec_pkg::IDX_SETUP_SECOND, 32'hffff_ffff);
        msr(1'h0, pec_pkg::IDX_SETUP_SECOND, 32'h0);
        chk("second setup", rd, 40'h00_ff9f_ffff);
        msr(1'h1, pec_pkg::IDX_COUNT_FIRST, 32'h8000_0000);
        cpl = 2'h3;
        msr(1'h1, pec_pkg::IDX_COUNT_FIRST, 32'h1);
        chk("refused data", rd, 40'h0);
        pmc(1'h0, 40'hff_8000_0000);
        cpl = 2'h0;
        msr(1'h1, pec_pkg::IDX_SETUP_SECOND, 32'h0);
    endtask
    task automatic t_run(input logic [31:0] s0, input logic [31:0] s1, input logic [1:0] c, input logic [3:0] a,
        input int n, input logic [39:0] e0, input logic [39:0] e1);
        msr(1'h1, pec_pkg::IDX_COUNT_FIRST, 32'h0);
        msr(1'h1, pec_pkg::IDX_COUNT_SECOND, 32'h0);
        msr(1'h1, pec_pkg::IDX_SETUP_SECOND, s1);
        msr(1'h1, pec_pkg::IDX_SETUP_FIRST, s0);
        chk("qualifier first", eq0, s0[15:8]);
        chk("qualifier second", eq1, s1[15:8]);
        {cpl, act0, act1} = {c, a, a};
        tick(n);
        // stop both counters, idle cycles still pass a less-than compare
        {cpl, act0, act1} = {2'h0, 8'h00};
        msr(1'h1, pec_pkg::IDX_SETUP_FIRST, 32'h0);
        pmc(1'h0, e0);
        pmc(1'h1, e1);
    endtask
    task automatic t_pin(input logic [31:0] s, input logic [31:0] c, input logic [39:0] e, input logic p, q);
        logic [1:0] pin_seen, irq_seen;
        msr(1'h1, pec_pkg::IDX_SETUP_SECOND, s);
        msr(1'h1, pec_pkg::IDX_COUNT_FIRST, c);
        msr(1'h1, pec_pkg::IDX_COUNT_SECOND, c);
        msr(1'h1, pec_pkg::IDX_SETUP_FIRST, s);
        {cpl, act0, act1, pin_seen, irq_seen} = {2'h3, 4'h3, 4'h3, 4'h0};
        repeat (12)
        begin
            tick(1);
            {act0, act1} = 8'h00;
            pin_seen |= monitor_pin;
            irq_seen |= perf_irq;
        end
        cpl = 2'h0;
        chk("monitor pin first", pin_seen[0], p);
        chk("monitor pin second", pin_seen[1], p);
        chk("interrupt first", irq_seen[0], q);
        chk("interrupt second", irq_seen[1], q);
        pmc(1'h0, e);
        pmc(1'h1, e);
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial
    begin
        tick(4);
        rst_n = 1'h1;
        t_regs();
        t_run(32'h0041_0001, 32'h0001_5a02, 2'h3, 4'h3, 4, 40'hc, 40'hc);
        t_run(32'h0041_0001, 32'h0000_0000, 2'h3, 4'h1, 5, 40'h5, 40'h0);
        t_run(32'h0041_0001, 32'h0001_5a02, 2'h0, 4'h3, 4, 40'h0, 40'h0);
        t_run(32'h0042_0001, 32'h0002_5a02, 2'h0, 4'h2, 3, 40'h6, 40'h6);
        t_run(32'h0043_0001, 32'h0003_5a02, 2'h3, 4'h3, 4, 40'hc, 40'hc);
        t_run(32'h0040_0001, 32'h0000_5a02, 2'h3, 4'h3, 4, 40'h0, 40'h0);
        t_run(32'h0001_0001, 32'h0001_5a02, 2'h3, 4'h3, 4, 40'h0, 40'h0);
        t_run(32'h0241_0001, 32'h0201_5a02, 2'h3, 4'h3, 4, 40'h4, 40'h4);
        t_run(32'h0441_0001, 32'h0401_5a02, 2'h3, 4'h3, 4, 40'h0, 40'h0);
        t_run(32'h04c1_0001, 32'h0481_5a02, 2'h3, 4'h3, 4, 40'h4, 40'h4);
        t_run(32'h00c1_0001, 32'h0081_5a02, 2'h3, 4'h3, 4, 40'hc, 40'hc);
        t_run(32'h0045_0001, 32'h0005_5a02, 2'h3, 4'h3, 4, 40'h1, 40'h1);
        t_pin(32'h0049_0001, 32'h0, 40'h3, 1'h1, 1'h0);
        t_pin(32'h0041_0001, 32'hffff_fffe, 40'h1, 1'h1, 1'h0);
        t_pin(32'h0051_0001, 32'hffff_fffe, 40'h1, 1'h1, 1'h1);
        t_pin(32'h0041_0001, 32'h0, 40'h3, 1'h0, 1'h0);
        finish_test();
    end
    initial
    begin
        #1_000_000;
        error_cnt++;
        finish_test();
    end
endmodule
